// File: rtl/ccpu_pkg.sv
// Package for the capture/compare/PWM unit: register map, fields, modes.
// Assumes one clock domain at the instruction clock rate.
package ccpu_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam int CCPU_NTMR = 2;
	localparam logic [7:0] ADDR_TMR_BASE = 8'h00;
	localparam logic [7:0] TMR_STRIDE = 8'h10;
	localparam logic [7:0] OFS_TCTRL = 8'h00;
	localparam logic [7:0] OFS_TPER = 8'h04;
	localparam logic [7:0] OFS_TCNT = 8'h08;
	localparam logic [7:0] ADDR_CMP_CTRL = 8'h20;
	localparam logic [7:0] ADDR_CMP_PRI = 8'h24;
	localparam logic [7:0] ADDR_CMP_SEC = 8'h28;
	localparam logic [7:0] ADDR_CAP_CTRL = 8'h30;
	localparam logic [7:0] ADDR_CAP_VAL = 8'h34;
	localparam logic [7:0] ADDR_FLAGS = 8'h38;
	// ----------------------------------------
	// Fields
	// ----------------------------------------
	localparam int TCTRL_RUN_BIT = 15;
	localparam int PS_W = 2;
	localparam int MODE_W = 3;
	localparam int CTRL_TSEL_BIT = 3;
	localparam int CMP_FAULT_BIT = 4;
	localparam int FLAG_CMP = 0;
	localparam int FLAG_CAP = 1;
	localparam int FLAG_TMR_LSB = 2;
	localparam logic [7:0] PS_LIMIT [4] = '{8'h00, 8'h07, 8'h3f, 8'hff};
	// ----------------------------------------
	// Compare modes
	// ----------------------------------------
	localparam logic [2:0] CMP_OFF = 3'h0;
	localparam logic [2:0] CMP_SET_HIGH = 3'h1;
	localparam logic [2:0] CMP_SET_LOW = 3'h2;
	localparam logic [2:0] CMP_TOGGLE = 3'h3;
	localparam logic [2:0] CMP_DUAL_ONE = 3'h4;
	localparam logic [2:0] CMP_DUAL_CONT = 3'h5;
	localparam logic [2:0] CMP_PWM = 3'h6;
	localparam logic [2:0] CMP_PWM_FAULT = 3'h7;
	// ----------------------------------------
	// Capture modes
	// ----------------------------------------
	localparam logic [2:0] CAP_OFF = 3'h0;
	localparam logic [2:0] CAP_BOTH = 3'h1;
	localparam logic [2:0] CAP_FALL = 3'h2;
	localparam logic [2:0] CAP_RISE = 3'h3;
	localparam logic [2:0] CAP_RISE4 = 3'h4;
	localparam logic [2:0] CAP_RISE16 = 3'h5;
	localparam logic [3:0] CAP_DIV4 = 4'h3;
	localparam logic [3:0] CAP_DIV16 = 4'hf;
endpackage : ccpu_pkg

// File: rtl/ccpu_unit.sv
// Capture/compare/PWM unit: two time bases, one capture, one compare.
// Assumes clk is the instruction clock and bus strobes are one cycle.
//
// Notes on behaviour
// - Enabled capture owns its input pin
// - Fault clears only after control rewrite
// - Compare picks its timer by select bit
// - Timer flag on every period match
// - Only the two fault pins cause faults
// - Fault puts compare output in high impedance
// - Fault reported through compare interrupt flag
// - Mode field offers two PWM modes
// - Runs on instruction clock, half oscillator
// - Unprescaled capture latches a later count
// - PWM edges placed to one cycle
// - Primary reloads from secondary each period
// - Low fault pin stops pulses, sets flag
// - Capture on rise, fall, 4th, 16th
// - Capture and compare pick either timer
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/10ps
module ccpu_unit
	import ccpu_pkg::*;
#(
	parameter int TW = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [TW-1:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [TW-1:0] rdata,
	input wire logic capture_input_pin,
	input wire logic fault_input_a,
	input wire logic fault_input_b,
	output logic compare_out,
	output logic compare_out_oe,
	output logic capture_pin_owned
);
	localparam int FW = FLAG_TMR_LSB + CCPU_NTMR;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic wr_cmp_ctrl;
	logic wr_cmp_pri;
	logic wr_cmp_sec;
	logic wr_cap_ctrl;
	logic wr_flags;
	assign wr_cmp_ctrl = wr_en && addr == ADDR_CMP_CTRL;
	assign wr_cmp_pri = wr_en && addr == ADDR_CMP_PRI;
	assign wr_cmp_sec = wr_en && addr == ADDR_CMP_SEC;
	assign wr_cap_ctrl = wr_en && addr == ADDR_CAP_CTRL;
	assign wr_flags = wr_en && addr == ADDR_FLAGS;

	// ----------------------------------------
	// Time bases
	// ----------------------------------------
	logic [TW-1:0] tmr_ctrl [CCPU_NTMR];
	logic [TW-1:0] tmr_per [CCPU_NTMR];
	logic [TW-1:0] tmr_cnt [CCPU_NTMR];
	logic [TW-1:0] tmr_cnt_d [CCPU_NTMR];
	logic [CCPU_NTMR-1:0] tmr_step;
	logic [CCPU_NTMR-1:0] tmr_match;
	logic [CCPU_NTMR-1:0] tmr_presc;
	logic [CCPU_NTMR-1:0] step_d_reg;

	for (genvar t = 0; t < CCPU_NTMR; t++) begin : g_tmr
		localparam logic [7:0] BASE = 8'(ADDR_TMR_BASE + TMR_STRIDE * t);
		logic [TW-1:0] ctrl_reg;
		logic [TW-1:0] per_reg;
		logic [TW-1:0] cnt_reg;
		logic [TW-1:0] cnt_d_reg;
		logic [7:0] ps_reg;
		logic run;
		logic tick;
		logic wr_ctrl;
		logic wr_per;
		assign wr_ctrl = wr_en && addr == 8'(BASE + OFS_TCTRL);
		assign wr_per = wr_en && addr == 8'(BASE + OFS_TPER);
		assign run = ctrl_reg[TCTRL_RUN_BIT];
		// One count per instruction cycle at prescale 1
		assign tick = run && ps_reg == PS_LIMIT[ctrl_reg[PS_W-1:0]];

		always_ff @(posedge clk) begin
			if (!rst_n) begin
				ctrl_reg <= '0;
				per_reg <= '0;
				cnt_reg <= '0;
				cnt_d_reg <= '0;
				ps_reg <= 8'h00;
			end else begin
				if (wr_ctrl)
					ctrl_reg <= wdata;
				if (wr_per)
					per_reg <= wdata;
				ps_reg <= (tick || !run) ? 8'h00 : ps_reg + 8'h01;
				if (tick)
					cnt_reg <= (cnt_reg == per_reg) ? '0 : cnt_reg + 1'b1;
				cnt_d_reg <= cnt_reg;
			end
		end

		assign tmr_ctrl[t] = ctrl_reg;
		assign tmr_per[t] = per_reg;
		assign tmr_cnt[t] = cnt_reg;
		assign tmr_cnt_d[t] = cnt_d_reg;
		assign tmr_step[t] = tick;
		// No postscaler: every period match is an event
		assign tmr_match[t] = tick && cnt_reg == per_reg;
		assign tmr_presc[t] = ctrl_reg[PS_W-1:0] != '0;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			step_d_reg <= '0;
		else
			step_d_reg <= tmr_step;
	end

	// ----------------------------------------
	// Compare / PWM
	// ----------------------------------------
	logic [TW-1:0] cmp_ctrl_reg, cmp_ctrl_next, pri_reg, pri_next, sec_reg;
	logic out_reg, out_next, oe_reg, oe_next, fault_reg, fault_next, shot_reg, shot_next;
	logic [MODE_W-1:0] cmp_mode;
	logic cmp_evt, cmp_tsel, c_match, pri_hit, sec_hit, is_pwm, fault_low, fault_set;

	assign cmp_mode = cmp_ctrl_reg[MODE_W-1:0];
	assign cmp_tsel = cmp_ctrl_reg[CTRL_TSEL_BIT];
	assign c_match = tmr_match[cmp_tsel];
	// Count compared in the cycle after it changes
	assign pri_hit = step_d_reg[cmp_tsel] && tmr_cnt[cmp_tsel] == pri_reg;
	assign sec_hit = step_d_reg[cmp_tsel] && tmr_cnt[cmp_tsel] == sec_reg;
	assign is_pwm = cmp_mode == CMP_PWM || cmp_mode == CMP_PWM_FAULT;
	// No comparator path exists into the fault logic
	assign fault_low = !fault_input_a || !fault_input_b;
	assign fault_set = cmp_mode == CMP_PWM_FAULT && fault_low;
	// Set wins; clear needs pins high and a control rewrite
	assign fault_next = fault_set ? 1'b1 : (wr_cmp_ctrl && !fault_low) ? 1'b0 : fault_reg;
	assign cmp_ctrl_next = wr_cmp_ctrl ? wdata : cmp_ctrl_reg;
	// Fault floats the pin; no software drive level
	assign oe_next = cmp_ctrl_next[MODE_W-1:0] != CMP_OFF && !fault_next;
	// Software write wins over the period reload
	assign pri_next = wr_cmp_pri ? wdata : (is_pwm && c_match && !fault_reg) ? sec_reg : pri_reg;

	always_comb begin
		out_next = out_reg;
		shot_next = shot_reg;
		cmp_evt = 1'b0;
		if (wr_cmp_ctrl) begin
			out_next = wdata[MODE_W-1:0] == CMP_SET_LOW;
			shot_next = 1'b0;
		end else if (fault_next) begin
			out_next = 1'b0;
		end else begin
			case (cmp_mode)
				CMP_SET_HIGH: begin
					if (pri_hit) begin
						out_next = 1'b1;
						cmp_evt = 1'b1;
					end
				end
				CMP_SET_LOW: begin
					if (pri_hit) begin
						out_next = 1'b0;
						cmp_evt = 1'b1;
					end
				end
				CMP_TOGGLE: begin
					if (pri_hit) begin
						out_next = !out_reg;
						cmp_evt = 1'b1;
					end
				end
				CMP_DUAL_ONE, CMP_DUAL_CONT: begin
					if (pri_hit && !shot_reg) begin
						out_next = 1'b1;
					end else if (sec_hit && out_reg) begin
						out_next = 1'b0;
						cmp_evt = 1'b1;
						shot_next = cmp_mode == CMP_DUAL_ONE;
					end
				end
				CMP_PWM, CMP_PWM_FAULT: begin
					if (c_match) begin
						out_next = 1'b1;
						cmp_evt = 1'b1;
					end else if (pri_hit) begin
						out_next = 1'b0;
					end
				end
				default: out_next = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmp_ctrl_reg <= '0;
			pri_reg <= '0;
			sec_reg <= '0;
			out_reg <= 1'b0;
			oe_reg <= 1'b0;
			fault_reg <= 1'b0;
			shot_reg <= 1'b0;
		end else begin
			cmp_ctrl_reg <= cmp_ctrl_next;
			pri_reg <= pri_next;
			if (wr_cmp_sec)
				sec_reg <= wdata;
			out_reg <= out_next;
			oe_reg <= oe_next;
			fault_reg <= fault_next;
			shot_reg <= shot_next;
		end
	end

	assign compare_out = out_reg;
	assign compare_out_oe = oe_reg;

	// ----------------------------------------
	// Capture
	// ----------------------------------------
	logic [TW-1:0] cap_ctrl_reg, cap_val_reg, cap_src;
	logic [3:0] div_reg, div_next, div_lim;
	logic [MODE_W-1:0] cap_mode;
	logic pin_s_reg, pin_d_reg, own_reg, cap_tsel, rise, fall, cap_evt, is_div;

	assign cap_mode = cap_ctrl_reg[MODE_W-1:0];
	assign cap_tsel = cap_ctrl_reg[CTRL_TSEL_BIT];
	assign rise = pin_s_reg && !pin_d_reg;
	assign fall = !pin_s_reg && pin_d_reg;
	assign is_div = cap_mode == CAP_RISE4 || cap_mode == CAP_RISE16;
	assign div_lim = cap_mode == CAP_RISE16 ? CAP_DIV16 : CAP_DIV4;
	assign div_next = (wr_cap_ctrl || !is_div) ? 4'h0 : !rise ? div_reg : (div_reg == div_lim) ? 4'h0 : div_reg + 4'h1;
	// Prescaled base: take the count from the edge cycle itself
	assign cap_src = tmr_presc[cap_tsel] ? tmr_cnt_d[cap_tsel] : tmr_cnt[cap_tsel];

	always_comb begin
		case (cap_mode)
			CAP_BOTH: cap_evt = rise || fall;
			CAP_FALL: cap_evt = fall;
			CAP_RISE: cap_evt = rise;
			CAP_RISE4, CAP_RISE16: cap_evt = rise && div_reg == div_lim;
			default: cap_evt = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cap_ctrl_reg <= '0;
			cap_val_reg <= '0;
			pin_s_reg <= 1'b0;
			pin_d_reg <= 1'b0;
			own_reg <= 1'b0;
			div_reg <= 4'h0;
		end else begin
			if (wr_cap_ctrl)
				cap_ctrl_reg <= wdata;
			if (cap_evt)
				cap_val_reg <= cap_src;
			pin_s_reg <= capture_input_pin;
			pin_d_reg <= pin_s_reg;
			own_reg <= (wr_cap_ctrl ? wdata[MODE_W-1:0] : cap_mode) != CAP_OFF;
			div_reg <= div_next;
		end
	end

	assign capture_pin_owned = own_reg;

	// ----------------------------------------
	// Flags and read-back
	// ----------------------------------------
	logic [FW-1:0] flags_reg;
	logic [FW-1:0] flags_set;
	logic [FW-1:0] flags_clr;
	logic [TW-1:0] rd_mux;
	logic [TW-1:0] rdata_reg;

	assign flags_set = {tmr_match, cap_evt, cmp_evt || (fault_set && !fault_reg)};
	assign flags_clr = wr_flags ? wdata[FW-1:0] : '0;

	always_comb begin
		rd_mux = '0;
		if (addr == ADDR_CMP_CTRL) begin
			rd_mux = cmp_ctrl_reg;
			rd_mux[CMP_FAULT_BIT] = fault_reg;
		end else if (addr == ADDR_CMP_PRI) begin
			rd_mux = pri_reg;
		end else if (addr == ADDR_CMP_SEC) begin
			rd_mux = sec_reg;
		end else if (addr == ADDR_CAP_CTRL) begin
			rd_mux = cap_ctrl_reg;
		end else if (addr == ADDR_CAP_VAL) begin
			rd_mux = cap_val_reg;
		end else if (addr == ADDR_FLAGS) begin
			rd_mux[FW-1:0] = flags_reg;
		end else begin
			for (int i = 0; i < CCPU_NTMR; i++) begin
				if (addr == 8'(ADDR_TMR_BASE + TMR_STRIDE * i + OFS_TCTRL))
					rd_mux = tmr_ctrl[i];
				else if (addr == 8'(ADDR_TMR_BASE + TMR_STRIDE * i + OFS_TPER))
					rd_mux = tmr_per[i];
				else if (addr == 8'(ADDR_TMR_BASE + TMR_STRIDE * i + OFS_TCNT))
					rd_mux = tmr_cnt[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags_reg <= '0;
			rdata_reg <= '0;
		end else begin
			// Set beats a same-cycle clear
			flags_reg <= (flags_reg & ~flags_clr) | flags_set;
			rdata_reg <= rd_en ? rd_mux : '0;
		end
	end

	assign rdata = rdata_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_fault_hit;
		cmp_mode == CMP_PWM_FAULT && fault_low && !fault_reg;
	endsequence

	sequence s_fault_held;
		fault_reg && !compare_out_oe;
	endsequence

	a_capture_pin_owned: assert property ((cap_mode != CAP_OFF && !wr_cap_ctrl) |=> capture_pin_owned)
		else $error("capture pin not owned while enabled");
	a_fault_stays_set: assert property ((fault_reg && !wr_cmp_ctrl) |=> fault_reg)
		else $error("fault cleared without rewrite");
	a_timer_flag_every: assert property (tmr_match[0] |=> flags_reg[FLAG_TMR_LSB])
		else $error("timer match did not set flag");
	a_fault_from_pins: assert property ($rose(fault_reg) |-> $past(fault_low))
		else $error("fault without low fault pin");
	a_fault_hiz_flag: assert property (s_fault_hit |=> s_fault_held ##0 flags_reg[FLAG_CMP])
		else $error("fault did not float output or flag");
	a_pwm_reload_sec: assert property ((is_pwm && c_match && !fault_reg && !wr_cmp_pri) |=> pri_reg == $past(sec_reg))
		else $error("primary not reloaded from secondary");
	a_pwm_rise_match: assert property ((is_pwm && c_match && !fault_next && !wr_cmp_ctrl) |=> compare_out)
		else $error("pwm output not high after period match");
	a_pwm_fall_pri: assert property ((is_pwm && pri_hit && !c_match && !fault_next && !wr_cmp_ctrl) |=> !compare_out)
		else $error("pwm output not low at primary match");
	a_capture_count: assert property ((cap_evt && !tmr_presc[cap_tsel]) |=> cap_val_reg == $past(tmr_cnt[cap_tsel]))
		else $error("capture latched wrong count");
	a_read_unmapped: assert property ((rd_en && addr == 8'h3c) |=> rdata == '0)
		else $error("unmapped read not zero");
endmodule : ccpu_unit

// File: tb/ccpu_pins.sv
// Pin-side partner: capture edge source, two fault pins, the driven switch line.
// Assumes the bench moves the request levels right after rising edges.
`timescale 1ns/10ps
module ccpu_pins (
	input wire logic clk,
	input wire logic cap_req,
	input wire logic fault_a_req_n,
	input wire logic fault_b_req_n,
	input wire logic compare_out,
	input wire logic compare_out_oe,
	output logic capture_input_pin,
	output logic fault_input_a,
	output logic fault_input_b,
	output logic pin_level
);
	// ----------------------------------------
	// Switch line
	// ----------------------------------------
	logic last_reg = 1'b0;
	always_ff @(posedge clk) begin
		if (compare_out_oe) begin
			last_reg <= compare_out;
		end
	end
	// No pull on the line, so a released line must not look still driven
	assign pin_level = compare_out_oe ? compare_out : ~last_reg;
	// ----------------------------------------
	// Edge source and fault pins
	// ----------------------------------------
	assign capture_input_pin = cap_req;
	assign fault_input_a = fault_a_req_n;
	assign fault_input_b = fault_b_req_n;
endmodule : ccpu_pins

// File: tb/testbench.sv
// Self-checking bench for the capture/compare/PWM unit.
// Assumes the pin partner model and a 200 MHz instruction clock.
`timescale 1ns/10ps
module testbench
	import ccpu_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic cap_req = 1'b0;
	logic fa_n = 1'b1;
	logic fb_n = 1'b1;
	logic [15:0] rdata;
	logic cap_pin, fault_a, fault_b, pin_level, compare_out, compare_out_oe, owned;
	int num_errors = 0;
	int checked = 0;
	int hi, lo;
	localparam logic [7:0] RST_ADDRS [5] = '{ADDR_CMP_CTRL, ADDR_CMP_PRI, OFS_TPER, ADDR_CAP_VAL, 8'h3c};
	localparam logic [2:0] CMODES [5] = '{CAP_BOTH, CAP_FALL, CAP_RISE, CAP_RISE4, CAP_RISE16};
	localparam int CPULSES [5] = '{1, 1, 1, 4, 16};
	always #(real'(CLK_PERIOD_NS) / 2.0) clk = ~clk;
	ccpu_unit dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .capture_input_pin(cap_pin), .fault_input_a(fault_a), .fault_input_b(fault_b),
		.compare_out(compare_out), .compare_out_oe(compare_out_oe), .capture_pin_owned(owned));
	ccpu_pins pins (.clk(clk), .cap_req(cap_req), .fault_a_req_n(fa_n), .fault_b_req_n(fb_n),
		.compare_out(compare_out), .compare_out_oe(compare_out_oe), .capture_input_pin(cap_pin),
		.fault_input_a(fault_a), .fault_input_b(fault_b), .pin_level(pin_level));
	// ----------------------------------------
	// Reporting and bus tasks
	// ----------------------------------------
	task automatic results();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask : chk16
	task automatic chk1(input logic got, input logic exp, input string msg);
		chk16({15'h0000, got}, {15'h0000, exp}, msg);
	endtask : chk1
	task automatic wr(input logic [7:0] a_in, input logic [15:0] d_in);
		@(posedge clk);
		addr <= a_in;
		wdata <= d_in;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a_in, output logic [15:0] d_out);
		@(posedge clk);
		addr <= a_in;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		d_out = rdata;
	endtask : rd
	task automatic wait_pin(input logic lvl, output int n);
		n = 0;
		while (pin_level !== lvl) begin
			@(negedge clk);
			n++;
			if (n > 200) begin
				num_errors++;
				$display("unexpected at %0t: output pin wait ran out", $time);
				results();
			end
		end
	endtask : wait_pin
	// Whole cycles high and low, starting from the next rising edge of the line
	task automatic measure(output int h, output int l);
		int skip;
		wait_pin(1'b0, skip);
		wait_pin(1'b1, skip);
		wait_pin(1'b0, h);
		wait_pin(1'b1, l);
	endtask : measure
	task automatic set_pin(input logic lvl);
		@(posedge clk);
		cap_req <= lvl;
		repeat (4) @(posedge clk);
	endtask : set_pin
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [15:0] v;
		chk1(compare_out_oe, 1'b0, "oe after reset");
		chk1(owned, 1'b0, "pin owned after reset");
		for (int i = 0; i < 5; i++) begin
			rd(RST_ADDRS[i], v);
			chk16(v, 16'h0000, "reset or unmapped read");
		end
	endtask : t_reset
	task automatic t_pwm();
		logic [15:0] v;
		wr(ADDR_TMR_BASE + OFS_TPER, 16'h0003);
		wr(ADDR_CMP_SEC, 16'h0001);
		wr(ADDR_CMP_PRI, 16'h0001);
		wr(ADDR_CMP_CTRL, 16'(CMP_PWM));
		wr(ADDR_TMR_BASE + OFS_TCTRL, 16'h8000);
		measure(hi, lo);
		chk16(16'(hi), 16'h0002, "pwm high width");
		chk16(16'(lo), 16'h0002, "pwm low width");
		rd(ADDR_FLAGS, v);
		chk16(v & 16'h0005, 16'h0005, "match flags");
		wr(ADDR_FLAGS, 16'h0005);
		repeat (6) @(posedge clk);
		rd(ADDR_FLAGS, v);
		chk16(v & 16'h0004, 16'h0004, "timer flag again");
		wr(ADDR_CMP_SEC, 16'h0002);
		measure(hi, lo);
		measure(hi, lo);
		chk16(16'(hi), 16'h0003, "duty after reload");
		rd(ADDR_CMP_PRI, v);
		chk16(v, 16'h0002, "primary reloaded");
		wr(ADDR_CMP_SEC, 16'h0001);
	endtask : t_pwm
	task automatic t_tsel();
		wr(ADDR_TMR_BASE + TMR_STRIDE + OFS_TPER, 16'h0005);
		wr(ADDR_TMR_BASE + TMR_STRIDE + OFS_TCTRL, 16'h8000);
		for (int t = 1; t >= 0; t--) begin
			wr(ADDR_CMP_CTRL, 16'(CMP_PWM) | 16'(t << CTRL_TSEL_BIT));
			measure(hi, lo);
			measure(hi, lo);
			chk16(16'(hi), 16'h0002, "selected timer high");
			chk16(16'(lo), 16'(t == 1 ? 4 : 2), "selected timer low");
		end
	endtask : t_tsel
	task automatic t_fault();
		logic [15:0] v;
		wr(ADDR_CMP_CTRL, 16'(CMP_PWM_FAULT));
		for (int i = 0; i < 2; i++) begin
			measure(hi, lo);
			// Flag clear lands with fault entry, so only the fault can leave bit 0 set
			@(posedge clk);
			addr <= ADDR_FLAGS;
			wdata <= 16'h0001;
			wr_en <= 1'b1;
			fa_n <= (i != 0);
			fb_n <= (i == 0);
			@(posedge clk);
			wr_en <= 1'b0;
			@(negedge clk);
			chk1(compare_out_oe, 1'b0, "oe during fault");
			rd(ADDR_CMP_CTRL, v);
			chk16(v, 16'h0017, "fault status");
			@(posedge clk);
			fa_n <= 1'b1;
			fb_n <= 1'b1;
			repeat (10) @(negedge clk);
			chk1(compare_out_oe, 1'b0, "fault held after pin high");
			rd(ADDR_FLAGS, v);
			chk16(v & 16'h0001, 16'h0001, "compare flag on fault");
			wr(ADDR_CMP_CTRL, 16'(CMP_PWM_FAULT));
			measure(hi, lo);
			chk16(16'(hi), 16'h0002, "pulses restarted");
			chk1(compare_out_oe, 1'b1, "oe after restart");
		end
		// Plain PWM mode has no protection
		wr(ADDR_CMP_CTRL, 16'(CMP_PWM));
		@(posedge clk);
		fa_n <= 1'b0;
		measure(hi, lo);
		chk1(compare_out_oe, 1'b1, "plain pwm ignores fault pin");
		@(posedge clk);
		fa_n <= 1'b1;
	endtask : t_fault
	task automatic t_capture();
		logic [15:0] v, a;
		for (int m = 0; m < 5; m++) begin
			wr(ADDR_CAP_CTRL, 16'(CMODES[m]));
			wr(ADDR_FLAGS, 16'h0002);
			chk1(owned, 1'b1, "pin owned");
			for (int k = 1; k < CPULSES[m]; k++) begin
				set_pin(1'b1);
				set_pin(1'b0);
				rd(ADDR_FLAGS, v);
				chk16(v & 16'h0002, 16'h0000, "no early capture");
			end
			set_pin(1'b1);
			rd(ADDR_FLAGS, v);
			chk16(v & 16'h0002, {14'h0000, m != 1, 1'b0}, "capture on rise");
			set_pin(1'b0);
			rd(ADDR_FLAGS, v);
			chk16(v & 16'h0002, 16'h0002, "capture done");
		end
		wr(ADDR_CAP_CTRL, 16'(CAP_OFF));
		wr(ADDR_FLAGS, 16'h0002);
		chk1(owned, 1'b0, "pin released");
		set_pin(1'b1);
		set_pin(1'b0);
		rd(ADDR_FLAGS, v);
		chk16(v & 16'h0002, 16'h0000, "capture off ignores pin");
		// Edges exactly 20 cycles apart on a free-running unprescaled timer
		wr(ADDR_TMR_BASE + TMR_STRIDE + OFS_TPER, 16'hffff);
		wr(ADDR_CAP_CTRL, 16'(CAP_BOTH) | 16'h0008);
		@(posedge clk);
		cap_req <= 1'b1;
		repeat (10) @(posedge clk);
		rd(ADDR_CAP_VAL, a);
		repeat (8) @(posedge clk);
		cap_req <= 1'b0;
		repeat (6) @(posedge clk);
		rd(ADDR_CAP_VAL, v);
		chk16(v - a, 16'h0014, "capture spacing");
		wr(ADDR_CAP_VAL, 16'hffff);
		rd(ADDR_CAP_VAL, a);
		chk16(a, v, "capture value read only");
	endtask : t_capture
	task automatic t_compare();
		int n;
		wr(ADDR_CMP_CTRL, 16'(CMP_OFF));
		wr(ADDR_CMP_PRI, 16'h0001);
		wr(ADDR_CMP_SEC, 16'h0002);
		chk1(compare_out_oe, 1'b0, "compare off releases pin");
		wr(ADDR_CMP_CTRL, 16'(CMP_SET_LOW));
		@(negedge clk);
		chk1(pin_level, 1'b1, "set low starts high");
		wait_pin(1'b0, n);
		repeat (8) @(negedge clk);
		chk1(pin_level, 1'b0, "set low holds low");
		wr(ADDR_CMP_CTRL, 16'(CMP_SET_HIGH));
		@(negedge clk);
		chk1(pin_level, 1'b0, "set high starts low");
		wait_pin(1'b1, n);
		repeat (8) @(negedge clk);
		chk1(pin_level, 1'b1, "set high holds high");
		wr(ADDR_CMP_CTRL, 16'(CMP_TOGGLE));
		measure(hi, lo);
		chk16(16'(hi), 16'h0004, "toggle high width");
		chk16(16'(lo), 16'h0004, "toggle low width");
		wr(ADDR_CMP_CTRL, 16'(CMP_DUAL_CONT));
		measure(hi, lo);
		chk16(16'(hi), 16'h0001, "dual pulse high");
		chk16(16'(lo), 16'h0003, "dual pulse low");
		wr(ADDR_CMP_CTRL, 16'(CMP_DUAL_ONE));
		@(negedge clk);
		wait_pin(1'b1, n);
		wait_pin(1'b0, n);
		n = 0;
		repeat (12) begin
			@(negedge clk);
			n += int'(pin_level !== 1'b0);
		end
		chk16(16'(n), 16'h0000, "single pulse not repeated");
	endtask : t_compare
	task automatic t_offset();
		logic [15:0] a, v;
		wr(ADDR_CAP_CTRL, 16'(CAP_RISE) | 16'h0008);
		for (int p = 0; p < 2; p++) begin
			wr(ADDR_TMR_BASE + TMR_STRIDE + OFS_TCTRL, 16'h8000 | 16'(p));
			// Count read in the same cycle in which the pin rises
			@(posedge clk);
			addr <= ADDR_TMR_BASE + TMR_STRIDE + OFS_TCNT;
			rd_en <= 1'b1;
			cap_req <= 1'b1;
			@(posedge clk);
			rd_en <= 1'b0;
			#1;
			a = rdata;
			@(posedge clk);
			#1;
			chk16(rdata, 16'h0000, "read data stands one cycle");
			set_pin(1'b0);
			rd(ADDR_CAP_VAL, v);
			if (p == 0) begin
				chk1((v - a) inside {16'h0001, 16'h0002}, 1'b1, "unprescaled capture offset");
			end else begin
				chk16(v - a, 16'h0000, "prescaled capture offset");
			end
		end
	endtask : t_offset
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_pwm();
		t_tsel();
		t_fault();
		t_compare();
		t_capture();
		t_offset();
		results();
	end
endmodule : testbench
